// ### pc_stack_pkg.sv
// Constants and carrier types for the program counter and return stack
package pc_stack_pkg;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned STACK_DEPTH = 4;
    localparam int unsigned PORT_BITS = 3;
    localparam int unsigned UPPER_BITS = 9;
    localparam logic [ADDR_W-1:0] PC_RESET = 12'h000;
    localparam logic [ADDR_W-1:0] PC_STEP = 12'h001;
    localparam logic [1:0] NOP2_CYCLES = 2'h2;

    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_BRANCH = 4'h1,
        OP_CALL = 4'h2,
        OP_INTR = 4'h3,
        OP_RET = 4'h4,
        OP_PUSH_ACC = 4'h5,
        OP_POP_ACC = 4'h6,
        OP_TBL_ENTER = 4'h7,
        OP_TBL_EXIT = 4'h8,
        OP_BIO_BRANCH = 4'h9,
        OP_IO = 4'ha
    } op_t;

    typedef struct packed {
        op_t op;
        logic cond;
        logic [ADDR_W-1:0] target;
        logic [ADDR_W-1:0] acc_low;
        logic [PORT_BITS-1:0] port;
    } seq_req_t;

    typedef struct packed {
        logic [UPPER_BITS-1:0] upper;
        logic [PORT_BITS-1:0] low;
    } addr_bus_t;

    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_NOP1 = 2'b01,
        ST_NOP2 = 2'b11
    } seq_state_t;
endpackage

// ### program_counter_and_stack.sv
// Program counter, four-level return stack and program address drive
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Holds a 12-bit counter addressing the next instruction fetch.
// - After each fetch the counter increments for the next prefetch.
// - Reset line forces the counter to zero.
// - Counter loads next prefetch address on each falling clock output edge.
// - Buffered counter drives the program address bus except in reset, when the bus is released.
// - Nine upper bits dedicated; three low bits shared with port address.
// - True branch loads absolute 12-bit target; false branch just increments.
// - Call pushes the incremented counter, interrupt the counter itself, onto the stack top.
// - Return stack is four levels of twelve bits.
// - Push instruction places twelve low accumulator bits on stack top.
// - Every push shifts levels down, losing the bottom silently.
// - Pop moves stack top to accumulator low bits, shifting levels up.
// - Pop keeps bottom level, so repeated pops replicate it.
// - Table read and write occupy one stack level while executing.
// - Branch-on-pin instruction never branches; acts as two-cycle no-op.
module program_counter_and_stack
    import pc_stack_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Pipeline timing: high for one cycle at each clock output falling edge
    input wire logic clock_output_fall,
    // Decoded instruction request, sampled with the falling edge strobe
    input wire seq_req_t req,
    // Program address and port address outputs
    output logic [UPPER_BITS-1:0] program_address_pins,
    output logic [PORT_BITS-1:0] port_address_lines,
    output logic program_address_oe,
    // Stack and accumulator views
    output logic [ADDR_W-1:0] stack_top_level,
    output logic [ADDR_W-1:0] pop_data,
    output logic pop_valid,
    output logic busy
);

    // ==========================================================
    // Sequencer state
    logic [ADDR_W-1:0] pc_reg, pc_next;
    logic [ADDR_W-1:0] stack_reg [STACK_DEPTH], stack_next [STACK_DEPTH];
    seq_state_t state_reg, state_next;
    addr_bus_t bus_reg, bus_next;
    logic [ADDR_W-1:0] pop_data_reg, pop_data_next;
    logic pop_valid_reg, pop_valid_next;
    logic oe_reg, oe_next;
    logic push_en, pop_en, pop_acc;
    logic [ADDR_W-1:0] push_val;

    always_comb begin
        pc_next = pc_reg;
        state_next = state_reg;
        push_en = 1'b0;
        pop_en = 1'b0;
        push_val = pc_reg;
        pop_acc = 1'b0;
        if (clock_output_fall) begin
            unique case (state_reg)
                ST_RUN: begin
                    pc_next = pc_reg + PC_STEP;
                    unique case (req.op)
                        OP_BRANCH: begin
                            if (req.cond) begin
                                pc_next = req.target;
                            end
                        end
                        OP_CALL: begin
                            push_en = 1'b1;
                            push_val = pc_reg + PC_STEP;
                            pc_next = req.target;
                        end
                        OP_INTR: begin
                            // Interrupted fetch is refetched after return
                            push_en = 1'b1;
                            pc_next = req.target;
                        end
                        OP_RET: begin
                            pop_en = 1'b1;
                            pc_next = stack_reg[0];
                        end
                        OP_PUSH_ACC: begin
                            push_en = 1'b1;
                            push_val = req.acc_low;
                        end
                        OP_POP_ACC: begin
                            pop_en = 1'b1;
                            pop_acc = 1'b1;
                        end
                        OP_TBL_ENTER: begin
                            // Table access borrows one level for the resume address
                            push_en = 1'b1;
                            push_val = pc_reg + PC_STEP;
                            pc_next = req.acc_low;
                        end
                        OP_TBL_EXIT: begin
                            pop_en = 1'b1;
                            pc_next = stack_reg[0];
                        end
                        OP_BIO_BRANCH: begin
                            // Test pin absent: never taken, stall one extra cycle
                            state_next = ST_NOP1;
                        end
                        default: begin
                        end
                    endcase
                end
                ST_NOP1: begin
                    // Second no-op cycle; a request on this strobe is dropped
                    pc_next = pc_reg + PC_STEP;
                    state_next = ST_RUN;
                end
                ST_NOP2: begin
                    // Spare code, never entered; falls back to normal sequencing
                    state_next = ST_RUN;
                end
                default: state_next = ST_RUN;
            endcase
        end
    end

    // ==========================================================
    // Sequencer registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pc_reg <= PC_RESET;
            state_reg <= ST_RUN;
        end else begin
            pc_reg <= pc_next;
            state_reg <= state_next;
        end
    end

    // ==========================================================
    // Return stack, one generate loop iteration per level
    for (genvar i = 0; i < STACK_DEPTH; i++) begin : g_level
        // Word that slides into this level on a push and on a pop
        logic [ADDR_W-1:0] from_above, from_below;
        if (i == 0) begin : g_top
            assign from_above = push_val;
        end else begin : g_lower
            assign from_above = stack_reg[i-1];
        end
        if (i == STACK_DEPTH - 1) begin : g_bottom
            // Bottom holds its value on pop, so repeated pops replicate it
            assign from_below = stack_reg[i];
        end else begin : g_upper
            assign from_below = stack_reg[i+1];
        end
        always_comb begin
            stack_next[i] = stack_reg[i];
            if (push_en) begin
                // Bottom falls off with no overflow flag
                stack_next[i] = from_above;
            end else if (pop_en) begin
                stack_next[i] = from_below;
            end
        end
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                stack_reg[i] <= PC_RESET;
            end else begin
                stack_reg[i] <= stack_next[i];
            end
        end
    end

    // ==========================================================
    // Address bus: low bits carry port field during IN and OUT
    always_comb begin
        bus_next = pc_next;
        if (clock_output_fall && state_reg == ST_RUN && req.op == OP_IO) begin
            bus_next.low = req.port;
        end
        oe_next = 1'b1;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            // Bus is released in reset and shows zero from the first edge after it
            bus_reg <= '0;
            oe_reg <= 1'b0;
        end else begin
            bus_reg <= bus_next;
            oe_reg <= oe_next;
        end
    end

    // ==========================================================
    // Popped accumulator word; the valid pulse lasts one cycle
    always_comb begin
        pop_data_next = pop_data_reg;
        pop_valid_next = 1'b0;
        if (pop_acc) begin
            pop_data_next = stack_reg[0];
            pop_valid_next = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pop_data_reg <= PC_RESET;
            pop_valid_reg <= 1'b0;
        end else begin
            pop_data_reg <= pop_data_next;
            pop_valid_reg <= pop_valid_next;
        end
    end

    // ==========================================================
    // Output drive, all from flip-flops except the busy marker
    assign program_address_pins = bus_reg.upper;
    assign port_address_lines = bus_reg.low;
    assign program_address_oe = oe_reg;
    assign stack_top_level = stack_reg[0];
    assign pop_data = pop_data_reg;
    assign pop_valid = pop_valid_reg;
    assign busy = (state_reg != ST_RUN);

endmodule
`default_nettype wire

// ### program_counter_and_stack_chk.sv
// Concurrent checks on the program counter and stack ports
`timescale 1ns/10ps
`default_nettype none
module program_counter_and_stack_chk
    import pc_stack_pkg::*;
(
    // Clock, reset and request
    input wire logic clk,
    input wire logic nrst,
    input wire logic clock_output_fall,
    input wire seq_req_t req,
    // Observed outputs
    input wire logic [UPPER_BITS-1:0] program_address_pins,
    input wire logic [PORT_BITS-1:0] port_address_lines,
    input wire logic program_address_oe,
    input wire logic [ADDR_W-1:0] stack_top_level,
    input wire logic [ADDR_W-1:0] pop_data,
    input wire logic pop_valid,
    input wire logic busy
);
    wire logic [ADDR_W-1:0] pc = {program_address_pins, port_address_lines};
    wire logic take = clock_output_fall && !busy;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // ========================================
    // Port relations
    property p_oe; $past(nrst) |-> program_address_oe; endproperty
    a_oe: assert property (p_oe) else $error("bus released");
    property p_hold;
        !clock_output_fall |=> $stable(stack_top_level) && $stable(pc[11:3]);
    endproperty
    a_hold: assert property (p_hold) else $error("moved off strobe");
    property p_br;
        take && req.op == OP_BRANCH
            |=> pc == ($past(req.cond) ? $past(req.target) : $past(pc) + 12'h1);
    endproperty
    a_br: assert property (p_br) else $error("branch");
    property p_call;
        take && req.op == OP_CALL
            |=> pc == $past(req.target) && stack_top_level == $past(pc) + 12'h1;
    endproperty
    a_call: assert property (p_call) else $error("call");
    property p_ret; take && req.op == OP_RET |=> pc == $past(stack_top_level); endproperty
    a_ret: assert property (p_ret) else $error("return");
    property p_push;
        take && req.op == OP_PUSH_ACC |=> stack_top_level == $past(req.acc_low);
    endproperty
    a_push: assert property (p_push) else $error("push");
    property p_pop;
        take && req.op == OP_POP_ACC |=> pop_valid && pop_data == $past(stack_top_level);
    endproperty
    a_pop: assert property (p_pop) else $error("pop");
    property p_bio;
        take && req.op == OP_BIO_BRANCH |=> busy && pc == $past(pc) + 12'h1;
    endproperty
    a_bio: assert property (p_bio) else $error("no-op branch");
    property p_nop;
        clock_output_fall && busy |=> !busy && pc == $past(pc) + 12'h1;
    endproperty
    a_nop: assert property (p_nop) else $error("no-op second cycle");
endmodule
`default_nettype wire

// ### ext_program_memory.sv
// Behavioural external program memory on the program address bus
`timescale 1ns/10ps
`default_nettype none
module ext_program_memory (
    // Address bus
    input wire logic [11:0] addr,
    input wire logic oe,
    // Instruction word
    output logic [15:0] word
);
    // Released bus reads a fixed odd pattern, so a stale address never looks valid
    assign word = oe ? ({4'h0, addr} ^ 16'ha5a5) : 16'h5a5a;
endmodule
`default_nettype wire

// ### test_program_counter_and_stack.sv
// Self-checking bench for the program counter and return stack
`timescale 1ns/10ps
`default_nettype none
module test_program_counter_and_stack;
    import pc_stack_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic fall = 1'b0;
    seq_req_t req = '0;
    logic [8:0] pins;
    logic [2:0] lines;
    logic oe, pop_valid, busy;
    logic [11:0] top, pop_data;
    logic [15:0] word;
    int errors = 0;
    int n_compared = 0;
    int cycles = 0;
    wire logic [11:0] addr = {pins, lines};
    always #25 clk = ~clk;
    program_counter_and_stack DUT (.clk(clk), .nrst(nrst), .clock_output_fall(fall), .req(req),
        .program_address_pins(pins), .port_address_lines(lines), .program_address_oe(oe),
        .stack_top_level(top), .pop_data(pop_data), .pop_valid(pop_valid), .busy(busy));
    ext_program_memory MEM (.addr(addr), .oe(oe), .word(word));
    // ========================================
    // Shared tasks
    task check(input logic [23:0] got, input logic [23:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task step(input op_t op, input logic [11:0] t, input logic c);
        @(posedge clk);
        // Port field differs from the counter's low bits so the multiplex shows
        req <= '{op, c, t, t, 3'h6};
        fall <= 1'b1;
        @(posedge clk);
        fall <= 1'b0;
        #1;
    endtask
    task close_out();
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            errors++;
            close_out();
        end
    end
    // ========================================
    // Scenarios
    task t_reset();
        repeat (10) @(posedge clk);
        check(oe, 1'b0);
        check(addr, 12'h000);
        nrst <= 1'b1;
        @(posedge clk);
        #1;
        check(oe, 1'b1);
        check(word, 16'ha5a5);
    endtask
    task t_flow();
        step(OP_NONE, 12'h000, 1'b0);
        check(addr, 12'h001);
        step(OP_BRANCH, 12'h8f3, 1'b1);
        check(addr, 12'h8f3);
        step(OP_BRANCH, 12'h123, 1'b0);
        check(addr, 12'h8f4);
        step(OP_IO, 12'h000, 1'b0);
        check({pins, lines}, {9'h11e, 3'h6});
        @(posedge clk);
        #1;
        check(addr, 12'h8f5);
    endtask
    task t_call();
        step(OP_NONE, 12'h000, 1'b0);
        step(OP_CALL, 12'hfff, 1'b0);
        check({top, addr}, 24'h8f7fff);
        step(OP_INTR, 12'h004, 1'b0);
        check({top, addr}, 24'hfff004);
        step(OP_RET, 12'h000, 1'b0);
        check({top, addr}, 24'h8f7fff);
        step(OP_RET, 12'h000, 1'b0);
        check(addr, 12'h8f7);
    endtask
    task t_stack();
        for (int i = 1; i <= 5; i++) step(OP_PUSH_ACC, 12'(i), 1'b0);
        for (int i = 0; i < 5; i++) begin
            step(OP_POP_ACC, 12'h000, 1'b0);
            check({pop_valid, pop_data}, {1'b1, (i < 4) ? 12'(5 - i) : 12'h002});
        end
        check(top, 12'h002);
    endtask
    task t_table();
        step(OP_BRANCH, 12'h200, 1'b1);
        step(OP_TBL_ENTER, 12'h3c0, 1'b0);
        check({top, addr}, 24'h2013c0);
        step(OP_TBL_EXIT, 12'h000, 1'b0);
        check(addr, 12'h201);
        step(OP_BIO_BRANCH, 12'h7ff, 1'b1);
        check({busy, addr}, 13'h1202);
        step(OP_BRANCH, 12'h7ff, 1'b1);
        check({busy, addr}, 13'h0203);
        step(OP_NONE, 12'h000, 1'b0);
        check({busy, addr}, 13'h0204);
    endtask
    task t_rereset();
        step(OP_PUSH_ACC, 12'h5c3, 1'b0);
        @(posedge clk);
        nrst <= 1'b0;
        #1;
        check(oe, 1'b0);
        check({top, addr}, 24'h000000);
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        #1;
        check({oe, busy, pop_valid}, 3'h4);
        check({top, addr}, 24'h000000);
    endtask
    initial begin
        t_reset();
        t_flow();
        t_call();
        t_stack();
        t_table();
        t_rereset();
        close_out();
    end
endmodule
bind program_counter_and_stack program_counter_and_stack_chk CHK (.clk(clk), .nrst(nrst),
    .clock_output_fall(clock_output_fall), .req(req), .program_address_pins(program_address_pins),
    .port_address_lines(port_address_lines), .program_address_oe(program_address_oe),
    .stack_top_level(stack_top_level), .pop_data(pop_data), .pop_valid(pop_valid), .busy(busy));
`default_nettype wire
